// ### design/hsw_defs.svh
// Purpose: shared constants of the hot-swap supervisor and its host
// Assumes: 100 MHz core clock, one temperature lsb per degree
// Notes: definitions only
`ifndef HSW_DEFS_SVH
`define HSW_DEFS_SVH

// timing
`define HSW_CLK_MHZ 100
`define HSW_SAMPLE_PERIOD_US 1000
`define HSW_SAMPLE_CYCLES (`HSW_SAMPLE_PERIOD_US * `HSW_CLK_MHZ)
`define HSW_PULSE_US 10
`define HSW_PULSE_CYCLES (`HSW_PULSE_US * `HSW_CLK_MHZ)

// command codes
`define HSW_CMD_OPERATION 8'h03
`define HSW_CMD_OT_FAULT 8'h4F
`define HSW_CMD_OT_WARN 8'h51
`define HSW_CMD_VENDOR_STATUS 8'h80
`define HSW_CMD_TEMPERATURE 8'h8D
`define HSW_CMD_ALERT_MASK 8'hD8
`define HSW_CMD_DIAGNOSTIC 8'hE1
`define HSW_CMD_CLEAR_FLAGS 8'hF0

// operation values
`define HSW_OP_ON 8'h80
`define HSW_OP_OFF 8'h00

// reset values
`define HSW_OP_RESET 8'h80
`define HSW_WARN_RESET 16'h007D
`define HSW_FAULT_RESET 16'h0096
`define HSW_MASK_RESET 16'h0000
`define HSW_ADDR_BASE 7'h40

// field positions (combined_diagnostic_flags and alert mask share them)
`define HSW_VSF_SHORT 7
`define HSW_DIAG_SHORT 7
`define HSW_DIAG_LATCHED 4
`define HSW_DIAG_OT_WARN 3
`define HSW_DIAG_OT_FAULT 2
`define HSW_DIAG_OP_OFF 1

// host register offsets
`define HSW_HOST_CMD 8'h00
`define HSW_HOST_WDATA 8'h04
`define HSW_HOST_STATUS 8'h08
`define HSW_HOST_RDATA 8'h0C

// host register fields
`define HSW_HCMD_WRITE 8
`define HSW_HCMD_ADDR_LO 16
`define HSW_HCMD_RESTART 30
`define HSW_HCMD_GO 31
`define HSW_HST_BUSY 0
`define HSW_HST_ACK 1
`define HSW_HST_ALERT 2

`endif

// ### design/hsw_pkg.sv
// Purpose: types of the hot-swap supervisor
// Assumes: nothing
// Notes: constants live in hsw_defs.svh
package hsw_pkg;
  typedef enum logic [1:0] {HSW_IDLE, HSW_REQ, HSW_WAIT} hsw_host_state_t;
  typedef logic [1:0] hsw_strap_t;
endpackage

// ### design/hsw_if.sv
// Purpose: management link between host controller and supervisor
// Assumes: both ends on ref_clk
// Notes: one command in flight at a time
`timescale 1ns/10ps
interface hsw_if;
  logic cmdValid;
  logic cmdReady;
  logic cmdWrite;
  logic [6:0] cmdAddr;
  logic [7:0] cmdCode;
  logic [15:0] cmdWdata;
  logic rspValid;
  logic rspAck;
  logic [15:0] rspData;
  logic alertN;
  modport dev (
    input cmdValid, cmdWrite, cmdAddr, cmdCode, cmdWdata,
    output cmdReady, rspValid, rspAck, rspData, alertN
  );
  modport host (
    output cmdValid, cmdWrite, cmdAddr, cmdCode, cmdWdata,
    input cmdReady, rspValid, rspAck, rspData, alertN
  );
endinterface

// ### design/hsw_device.sv
// Purpose: supervisor logic of a hot-swap protection controller
// Assumes: rst_n is the power-on reset; temperature code is same-clock
// Notes: analog limiting and fault timer ramps stay outside
//
// Contract
// - temperature sample pulse once per millisecond
// - temperature read command returns latest sample
// - alert low above warning threshold
// - pass switch off above fault threshold
// - thresholds rewritable, new values used
// - shorted switch flag in two registers
// - shorted flag pulls alert unless masked
// - enable low or overvoltage forces gate low
// - enable toggle clears latched-off state
// - enable and overvoltage leave settings alone
// - bus address latched from three-level straps
// - reference low holds reset, erases settings
// - address latched after reference release
// - operation 80h enables, 0h disables output
// - host restarts with 0h then 80h
// - latched-off bit held while latched
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/10ps
`include "hsw_defs.svh"
module hsw_device #(
  parameter int unsigned SAMPLE_CYCLES = `HSW_SAMPLE_CYCLES,
  parameter int unsigned PULSE_CYCLES = `HSW_PULSE_CYCLES
)(
  // clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // management link
  hsw_if.dev link,
  // supply and reference pins
  input wire logic enable_undervolt_input,
  input wire logic overvolt_input,
  input wire logic refReleased,
  // address straps, 0 ground, 1 open, 2 supply
  input wire logic [1:0] addr_strap_bit0,
  input wire logic [1:0] addr_strap_bit1,
  input wire logic [1:0] addr_strap_bit2,
  // analog side
  input wire logic senseAboveShort,
  input wire logic retryExhausted,
  input wire logic [15:0] tempCode,
  // outputs
  output logic tempPulse,
  output logic gateOn,
  output logic [6:0] busAddr
);
  localparam int NSYNC = 10;

  logic [NSYNC-1:0] pinRaw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic enPrev_r;
  logic logicRst;
  logic enOk;
  logic ovHigh;
  logic refOk;
  logic shortOk;
  logic [31:0] sampleCnt_r;
  logic [15:0] measTemp_r;
  logic [7:0] operation_r;
  logic [15:0] warnThr_r;
  logic [15:0] faultThr_r;
  logic [15:0] alertMask_r;
  logic shortFlag_r;
  logic latchedOff_r;
  logic addrValid_r;
  logic [6:0] addr_r;
  logic gateOn_r;
  logic otWarn;
  logic otFault;
  logic take;
  logic hit;
  logic [15:0] diagWord;
  logic [7:0] vendorStatus;
  logic rspValid_r;
  logic rspAck_r;
  logic [15:0] rspData_r;

  function automatic logic [6:0] strapLevel(input hsw_pkg::hsw_strap_t s);
    strapLevel = (s == 2'h0) ? 7'h00 : ((s == 2'h1) ? 7'h01 : 7'h02);
  endfunction

  assign pinRaw = {senseAboveShort, refReleased, overvolt_input,
                   enable_undervolt_input, addr_strap_bit2,
                   addr_strap_bit1, addr_strap_bit0};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end
        else
        begin
          sync1_r[gi] <= pinRaw[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  assign enOk = sync2_r[6];
  assign ovHigh = sync2_r[7];
  assign refOk = sync2_r[8];
  assign shortOk = sync2_r[9];

  // reference low holds logic reset
  // straps share the sync depth, so capture sees settled straps
  assign logicRst = !rst_n || !refOk;

  always_ff @(posedge ref_clk)
  begin
    if (logicRst)
    begin
      addrValid_r <= 1'b0;
      addr_r <= `HSW_ADDR_BASE;
    end
    else if (!addrValid_r)
    begin
      addrValid_r <= 1'b1;
      addr_r <= 7'(`HSW_ADDR_BASE + strapLevel(sync2_r[1:0])
                + 7'(3 * strapLevel(sync2_r[3:2]))
                + 7'(9 * strapLevel(sync2_r[5:4])));
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (logicRst)
      sampleCnt_r <= 32'h00000000;
    else if (sampleCnt_r == SAMPLE_CYCLES - 1)
      sampleCnt_r <= 32'h00000000;
    else
      sampleCnt_r <= sampleCnt_r + 32'h00000001;
  end

  // measurement current step while counter in pulse window
  assign tempPulse = !logicRst && (sampleCnt_r < PULSE_CYCLES);

  // sample taken at the end of the pulse, when the step has settled
  always_ff @(posedge ref_clk)
  begin
    if (logicRst)
      measTemp_r <= 16'h0000;
    else if (sampleCnt_r == PULSE_CYCLES - 1)
      measTemp_r <= tempCode;
  end

  assign take = link.cmdValid && link.cmdReady;
  assign hit = link.cmdAddr == addr_r;

  // settings written only over the link
  always_ff @(posedge ref_clk)
  begin
    if (logicRst)
    begin
      operation_r <= `HSW_OP_RESET;
      warnThr_r <= `HSW_WARN_RESET;
      faultThr_r <= `HSW_FAULT_RESET;
      alertMask_r <= `HSW_MASK_RESET;
    end
    else if (take && hit && link.cmdWrite)
    begin
      unique case (link.cmdCode)
        `HSW_CMD_OPERATION: operation_r <= link.cmdWdata[7:0];
        `HSW_CMD_OT_WARN: warnThr_r <= link.cmdWdata;
        `HSW_CMD_OT_FAULT: faultThr_r <= link.cmdWdata;
        `HSW_CMD_ALERT_MASK: alertMask_r <= link.cmdWdata;
        default: ;
      endcase
    end
  end

  assign otWarn = measTemp_r > warnThr_r;
  assign otFault = measTemp_r > faultThr_r;

  // sticky short flag, set beats clear
  always_ff @(posedge ref_clk)
  begin
    if (logicRst)
      shortFlag_r <= 1'b0;
    else if (shortOk && !gateOn_r)
      shortFlag_r <= 1'b1;
    else if (take && hit && link.cmdWrite
             && link.cmdCode == `HSW_CMD_CLEAR_FLAGS)
      shortFlag_r <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (logicRst)
    begin
      latchedOff_r <= 1'b0;
      enPrev_r <= 1'b0;
    end
    else
    begin
      enPrev_r <= enOk;
      if (retryExhausted)
        latchedOff_r <= 1'b1;
      else if (enPrev_r && !enOk)
        latchedOff_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (logicRst)
      gateOn_r <= 1'b0;
    else
      gateOn_r <= enOk && !ovHigh && operation_r == `HSW_OP_ON
                  && !otFault && !latchedOff_r && !retryExhausted;
  end
  assign gateOn = gateOn_r;
  assign busAddr = addr_r;

  always_comb
  begin
    diagWord = 16'h0000;
    diagWord[`HSW_DIAG_SHORT] = shortFlag_r;
    diagWord[`HSW_DIAG_LATCHED] = latchedOff_r;
    diagWord[`HSW_DIAG_OT_WARN] = otWarn;
    diagWord[`HSW_DIAG_OT_FAULT] = otFault;
    diagWord[`HSW_DIAG_OP_OFF] = operation_r != `HSW_OP_ON;
    vendorStatus = 8'h00;
    vendorStatus[`HSW_VSF_SHORT] = shortFlag_r;
  end

  // read answers one cycle after the take
  // cleared at power-on only: no take occurs under a reference reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rspValid_r <= 1'b0;
      rspAck_r <= 1'b0;
      rspData_r <= 16'h0000;
    end
    else
    begin
      rspValid_r <= take;
      rspAck_r <= take && hit;
      if (take)
      begin
        unique case (link.cmdCode)
          `HSW_CMD_OPERATION: rspData_r <= {8'h00, operation_r};
          `HSW_CMD_OT_WARN: rspData_r <= warnThr_r;
          `HSW_CMD_OT_FAULT: rspData_r <= faultThr_r;
          `HSW_CMD_ALERT_MASK: rspData_r <= alertMask_r;
          `HSW_CMD_TEMPERATURE: rspData_r <= measTemp_r;
          `HSW_CMD_VENDOR_STATUS: rspData_r <= {8'h00, vendorStatus};
          `HSW_CMD_DIAGNOSTIC: rspData_r <= diagWord;
          default: rspData_r <= 16'h0000;
        endcase
      end
    end
  end

  // no command taken while in reset or before the address is known
  assign link.cmdReady = !logicRst && addrValid_r;
  assign link.rspValid = rspValid_r;
  assign link.rspAck = rspAck_r;
  assign link.rspData = rspData_r;

  // alert from unmasked warning or unmasked short
  assign link.alertN = !((otWarn && !alertMask_r[`HSW_DIAG_OT_WARN])
                        || (shortFlag_r && !alertMask_r[`HSW_DIAG_SHORT]));
endmodule

// ### design/hsw_host.sv
// Purpose: host controller bridging AHB-Lite to the management link
// Assumes: single slave, zero wait states, word accesses
// Notes: one link command at a time
`timescale 1ns/10ps
`include "hsw_defs.svh"
module hsw_host (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // management link
  hsw_if.host link
);
  hsw_pkg::hsw_host_state_t state_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic [31:0] cmdReg_r;
  logic [15:0] wdata_r;
  logic [15:0] rdata_r;
  logic ack_r;
  logic second_r;
  logic [31:0] hrdata_r;
  logic addrPhase;
  logic goNow;
  logic restartNow;

  // only whole-word transfers are taken
  assign addrPhase = hsel && hready && htrans[1] && hsize == 3'h2;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  // data phase of a write follows its address phase
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end
    else
    begin
      wrPend_r <= addrPhase && hwrite;
      wrAddr_r <= haddr[7:0];
    end
  end

  // read data latched at the address phase, shown in the data phase
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      hrdata_r <= 32'h00000000;
    else if (addrPhase && !hwrite)
    begin
      unique case (haddr[7:0])
        `HSW_HOST_CMD: hrdata_r <= {2'b00, cmdReg_r[29:0]};
        `HSW_HOST_WDATA: hrdata_r <= {16'h0000, wdata_r};
        `HSW_HOST_STATUS: hrdata_r <= {29'h00000000, !link.alertN,
                                       ack_r, state_r != hsw_pkg::HSW_IDLE};
        `HSW_HOST_RDATA: hrdata_r <= {16'h0000, rdata_r};
        default: hrdata_r <= 32'h00000000;
      endcase
    end
  end

  // commands written while busy are dropped
  assign goNow = wrPend_r && wrAddr_r == `HSW_HOST_CMD
                 && state_r == hsw_pkg::HSW_IDLE && hwdata[`HSW_HCMD_GO];
  assign restartNow = goNow && hwdata[`HSW_HCMD_RESTART];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cmdReg_r <= 32'h00000000;
      wdata_r <= 16'h0000;
    end
    else if (wrPend_r && state_r == hsw_pkg::HSW_IDLE)
    begin
      if (wrAddr_r == `HSW_HOST_CMD)
        cmdReg_r <= hwdata;
      else if (wrAddr_r == `HSW_HOST_WDATA)
        wdata_r <= hwdata[15:0];
    end
  end

  // wait on cmdReady while the device is held in reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      state_r <= hsw_pkg::HSW_IDLE;
      second_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end
    else
    begin
      unique case (state_r)
        hsw_pkg::HSW_IDLE:
          if (goNow)
          begin
            state_r <= hsw_pkg::HSW_REQ;
            second_r <= 1'b0;
          end
        hsw_pkg::HSW_REQ:
          if (link.cmdReady)
            state_r <= hsw_pkg::HSW_WAIT;
        hsw_pkg::HSW_WAIT:
          if (link.rspValid)
          begin
            ack_r <= link.rspAck;
            rdata_r <= link.rspData;
            if (cmdReg_r[`HSW_HCMD_RESTART] && !second_r)
            begin
              second_r <= 1'b1;
              state_r <= hsw_pkg::HSW_REQ;
            end
            else
              state_r <= hsw_pkg::HSW_IDLE;
          end
        default: state_r <= hsw_pkg::HSW_IDLE;
      endcase
    end
  end

  assign link.cmdValid = state_r == hsw_pkg::HSW_REQ;
  assign link.cmdAddr = cmdReg_r[`HSW_HCMD_ADDR_LO +: 7];
  assign link.cmdWrite = cmdReg_r[`HSW_HCMD_RESTART]
                         || cmdReg_r[`HSW_HCMD_WRITE];
  assign link.cmdCode = cmdReg_r[`HSW_HCMD_RESTART] ? `HSW_CMD_OPERATION
                        : cmdReg_r[7:0];
  assign link.cmdWdata = cmdReg_r[`HSW_HCMD_RESTART]
                         ? (second_r ? {8'h00, `HSW_OP_ON}
                                     : {8'h00, `HSW_OP_OFF})
                         : wdata_r;
endmodule

// ### bench/hsw_link_assertions.sv
// Purpose: link protocol checks between host controller and supervisor
// Assumes: one clock, synchronous active-low reset
// Notes: sees only the link signals, instantiated beside the interface
`timescale 1ns/10ps
module hsw_link_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdWdata,
  input wire logic rspValid,
  input wire logic rspAck,
  input wire logic [15:0] rspData,
  input wire logic alertN
);
  take_answer_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cmdValid && cmdReady |=> rspValid) else $error("no answer after take");
  answer_pulse_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rspValid |=> !rspValid) else $error("answer longer than one cycle");
  answer_cause_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rspValid |-> $past(cmdValid && cmdReady)) else $error("answer unasked");
  ack_in_answer_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rspAck |-> rspValid) else $error("ack outside answer");
  data_stands_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    !rspValid && $past(!rspValid) |-> $stable(rspData))
    else $error("answer data moved");
  // request held, one in flight
  cmd_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cmdValid && !cmdReady |=> cmdValid && $stable(cmdCode)
      && $stable(cmdWdata)) else $error("request dropped early");
  one_flight_a: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    cmdValid && cmdReady |=> !cmdValid && rspValid)
    else $error("second request");
  reset_ready_a: assert property (
    @(posedge ref_clk)
    !rst_n ##1 !rst_n |-> !cmdReady) else $error("ready during reset");
  reset_alert_a: assert property (
    @(posedge ref_clk)
    !rst_n ##1 !rst_n |-> alertN) else $error("alert during reset");
endmodule

// ### bench/hsw_tb_top.sv
// Purpose: end-to-end test of host controller and supervisor
// Assumes: short sample period, zero-wait AHB-Lite slave
// Notes: bus reads are queued and compared by a monitor
`timescale 1ns/10ps
`include "hsw_defs.svh"
module hot_swap_fault_enable_supervisor_tb_top;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, tempPulse, gateOn;
  logic [31:0] hrdata, rd, m;
  logic en = 1'b1;
  logic refPin = 1'b1;
  logic [2:0] hsize = 3'h2;
  logic ov = 1'b0;
  logic sense = 1'b0;
  logic retry = 1'b0;
  logic rdPh = 1'b0;
  logic [15:0] temp, w;
  hsw_pkg::hsw_strap_t s0, s1, s2;
  logic [6:0] busAddr, addr;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  integer seed = 32'h4270;
  int fail_count = 0;
  int check_count = 0;
  int n;
  always #5 ref_clk = ~ref_clk;
  hsw_if link ();
  // short counts keep the run brief
  hsw_device #(.SAMPLE_CYCLES(200), .PULSE_CYCLES(5)) u_hsw_device (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .enable_undervolt_input(en), .overvolt_input(ov), .refReleased(refPin),
    .addr_strap_bit0(s0), .addr_strap_bit1(s1), .addr_strap_bit2(s2),
    .senseAboveShort(sense), .retryExhausted(retry), .tempCode(temp),
    .tempPulse(tempPulse), .gateOn(gateOn), .busAddr(busAddr));
  hsw_host u_hsw_host (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .link(link));
  hsw_link_checker u_hsw_link_checker (
    .ref_clk(ref_clk), .rst_n(rst_n), .cmdValid(link.cmdValid),
    .cmdReady(link.cmdReady), .cmdCode(link.cmdCode),
    .cmdWdata(link.cmdWdata), .rspValid(link.rspValid),
    .rspAck(link.rspAck), .rspData(link.rspData), .alertN(link.alertN));
  function automatic int rnd(input int lim);
    return $unsigned($random(seed)) % lim;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] ex);
    check_count++;
    if (got !== ex)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, ex);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic rdy();
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
  endtask
  // one single transfer; a nonzero mask queues a compare of read data
  task automatic ahb(input logic wr, input logic [31:0] a, d, ex, mk);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdPh <= !wr && mk != 32'h0;
    if (!wr && mk != 32'h0)
    begin
      expQ.push_back(ex);
      mskQ.push_back(mk);
    end
    rdy();
    rd = hrdata;
    rdPh <= 1'b0;
    hsel <= 1'b0;
  endtask
  // command word goes, then status is polled until busy drops
  task automatic go(input logic [31:0] word);
    ahb(1'b1, 32'h0, word, 32'h0, 32'h0);
    rd = 32'h1;
    while (rd[0] !== 1'b0)
      ahb(1'b0, 32'h8, 32'h0, 32'h0, 32'h0);
  endtask
  task automatic cmd(input logic [7:0] c, input logic wr,
                     input logic [6:0] ad, input logic [15:0] d);
    ahb(1'b1, 32'h4, {16'h0, d}, 32'h0, 32'h0);
    go({2'b10, 7'h0, ad, 7'h0, wr, c});
  endtask
  task automatic reg_rd(input logic [7:0] c, input logic [31:0] ex, mk);
    cmd(c, 1'b0, addr, 16'h0);
    ahb(1'b0, 32'hC, 32'h0, ex, mk);
  endtask
  // monitor: oldest note against each read answer
  always @(posedge ref_clk)
  begin
    if (rdPh === 1'b1 && hreadyout === 1'b1 && expQ.size() > 0)
    begin
      m = mskQ.pop_front();
      cmp(hrdata & m, expQ.pop_front() & m);
    end
  end
  initial
  begin
    #400000;
    fail_count++;
    close_out();
  end
  initial
  begin
    temp = 16'(rnd(100));
    s0 = 2'(rnd(3));
    s1 = 2'(rnd(3));
    s2 = 2'(rnd(3));
    addr = 7'(`HSW_ADDR_BASE + s0 + 3 * s1 + 9 * s2);
    wt(20);
    rst_n <= 1'b1;
    wt(250);
    cmp(busAddr, addr);
    cmp(gateOn, 1'b1);
    n = 0;
    repeat (1000) @(posedge ref_clk) n += tempPulse;
    cmp(n, 25);
    $display("test 1 done");
    reg_rd(`HSW_CMD_TEMPERATURE, temp, 32'hFFFF);
    ahb(1'b0, 32'h8, 32'h0, 32'h2, 32'h2);
    cmd(`HSW_CMD_TEMPERATURE, 1'b0, addr + 7'h1, 16'h0);
    ahb(1'b0, 32'h8, 32'h0, 32'h0, 32'h2);
    ahb(1'b0, 32'h10, 32'h0, 32'h0, 32'hFFFFFFFF);
    $display("test 2 done");
    for (int i = 0; i < 2; i++)
    begin
      w = i ? 16'h80 : 16'h0;
      cmd(`HSW_CMD_OPERATION, 1'b1, addr, w);
      wt(3);
      cmp(gateOn, i == 1);
      reg_rd(`HSW_CMD_DIAGNOSTIC, i ? 32'h0 : 32'h2, 32'h2);
    end
    $display("test 3 done");
    en <= 1'b0;
    wt(4);
    cmp(gateOn, 1'b0);
    en <= 1'b1;
    ov <= 1'b1;
    wt(4);
    cmp(gateOn, 1'b0);
    ov <= 1'b0;
    wt(4);
    cmp(gateOn, 1'b1);
    reg_rd(`HSW_CMD_OT_WARN, 32'h7D, 32'hFFFF);
    reg_rd(`HSW_CMD_OPERATION, 32'h80, 32'hFFFF);
    cmp(busAddr, addr);
    $display("test 4 done");
    w = 16'(40 + rnd(20));
    cmd(`HSW_CMD_OT_WARN, 1'b1, addr, w);
    cmd(`HSW_CMD_OT_FAULT, 1'b1, addr, w + 16'd10);
    temp <= w + 16'd5;
    wt(250);
    ahb(1'b0, 32'h8, 32'h0, 32'h4, 32'h4);
    cmp(gateOn, 1'b1);
    temp <= w + 16'd11;
    wt(250);
    cmp(gateOn, 1'b0);
    reg_rd(`HSW_CMD_DIAGNOSTIC, 32'hC, 32'hC);
    temp <= 16'd20;
    wt(250);
    cmp(gateOn, 1'b1);
    $display("test 5 done");
    cmd(`HSW_CMD_OPERATION, 1'b1, addr, 16'h0);
    wt(3);
    sense <= 1'b1;
    wt(4);
    sense <= 1'b0;
    reg_rd(`HSW_CMD_DIAGNOSTIC, 32'h80, 32'h80);
    reg_rd(`HSW_CMD_VENDOR_STATUS, 32'h80, 32'h80);
    ahb(1'b0, 32'h8, 32'h0, 32'h4, 32'h4);
    cmd(`HSW_CMD_ALERT_MASK, 1'b1, addr, 16'h80);
    ahb(1'b0, 32'h8, 32'h0, 32'h0, 32'h4);
    cmd(`HSW_CMD_CLEAR_FLAGS, 1'b1, addr, 16'h0);
    cmd(`HSW_CMD_ALERT_MASK, 1'b1, addr, 16'h0);
    reg_rd(`HSW_CMD_DIAGNOSTIC, 32'h0, 32'h80);
    cmd(`HSW_CMD_OPERATION, 1'b1, addr, 16'h80);
    $display("test 6 done");
    retry <= 1'b1;
    wt(1);
    retry <= 1'b0;
    wt(3);
    cmp(gateOn, 1'b0);
    wt(20);
    reg_rd(`HSW_CMD_DIAGNOSTIC, 32'h10, 32'h10);
    en <= 1'b0;
    wt(5);
    en <= 1'b1;
    wt(5);
    reg_rd(`HSW_CMD_DIAGNOSTIC, 32'h0, 32'h10);
    cmp(gateOn, 1'b1);
    $display("test 7 done");
    // restart from 80h: last answer shows the 00h step
    go({2'b11, 7'h0, addr, 16'h0});
    ahb(1'b0, 32'hC, 32'h0, 32'h0, 32'hFFFF);
    reg_rd(`HSW_CMD_OPERATION, 32'h80, 32'hFFFF);
    cmp(gateOn, 1'b1);
    $display("test 8 done");
    cmd(`HSW_CMD_OT_FAULT, 1'b1, addr, 16'h33);
    refPin <= 1'b0;
    s0 <= 2'(rnd(3));
    s2 <= 2'(rnd(3));
    wt(4);
    cmp(link.cmdReady, 1'b0);
    refPin <= 1'b1;
    wt(4);
    addr = 7'(`HSW_ADDR_BASE + s0 + 3 * s1 + 9 * s2);
    cmp(busAddr, addr);
    reg_rd(`HSW_CMD_OT_FAULT, 32'h96, 32'hFFFF);
    $display("test 9 done");
    cmd(`HSW_CMD_OT_FAULT, 1'b1, addr, 16'h33);
    rst_n <= 1'b0;
    wt(5);
    rst_n <= 1'b1;
    wt(3);
    reg_rd(`HSW_CMD_OT_FAULT, 32'h96, 32'hFFFF);
    $display("test 10 done");
    wt(3);
    close_out();
  end
endmodule
